//--- debug_trace_and_reset_modes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trace_and_reset_modes_tb;
    import dtr_pkg::*;

    typedef struct packed {
        logic        wr;
        logic [31:0] addr;
        logic [31:0] data;
        logic        cach;
        logic        instr;
        logic        burst;
    } dtr_note_t;

    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        float_n = 1'b1;
    logic        tc_i = 1'b0;
    logic        grant_i = 1'b0;
    logic        bus_ack;
    logic [1:0]  wait_cycles = 2'h0;
    logic [31:0] trc_word;
    logic        trc_ok;
    logic [22:0] tag_i = '0;
    dtr_index_t  index_i = '0;
    dtr_mode_t   mode_pins_i = '0;
    dtr_access_t acc_i = '0;
    dtr_mode_t   mode_o;
    dtr_bus_t    bus_o;
    logic        core_run, acc_taken, ext_req, burst, bclk, bclk_oe, tc_o, tc_oe, gnt_o, gnt_oe;
    dtr_note_t   notes[$];
    int          miscompares = 0;
    int          samples_checked = 0;
    int          seed = 32'hf835_86ed;
    logic        prev_ale = 1'b0;
    logic        prev_strb = 1'b1;

    initial forever #20 clk_i = ~clk_i;

    dtr_debug_core dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .mode_pins_i(mode_pins_i),
        .float_all_outputs_n_i(float_n), .acc_i(acc_i), .bus_ack_i(bus_ack),
        .tag_i(tag_i), .index_i(index_i), .tc_i(tc_i), .grant_i(grant_i),
        .mode_o(mode_o), .core_run_o(core_run), .acc_taken_o(acc_taken),
        .ext_req_o(ext_req), .burst_o(burst), .bus_clock_out_o(bclk),
        .bus_clock_out_oe_o(bclk_oe), .bus_o(bus_o), .terminal_count_out_o(tc_o),
        .terminal_count_out_oe_o(tc_oe), .bus_grant_out_o(gnt_o),
        .bus_grant_out_oe_o(gnt_oe));

    dtr_tracer partner (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_clock_i(bclk), .bus_i(bus_o),
        .wait_i(wait_cycles), .bus_ack_o(bus_ack), .trace_o(trc_word), .trace_ok_o(trc_ok));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic stop_test();
        if (notes.size() != 0) miscompares++;
        $display("compares %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Address phase and strobe phase checked against the oldest note
    always @(negedge clk_i) begin
        if (bus_o.ale === 1'b1 && prev_ale === 1'b0) begin
            if (notes.size() == 0) chk(1, 0, "unexpected bus cycle");
            else begin
                chk(bus_o.ad, notes[0].addr, "cycle address");
                chk({31'h0, bus_o.diag}, {31'h0, notes[0].cach}, "miss marker");
                chk({31'h0, burst}, {31'h0, notes[0].burst}, "burst kind");
            end
        end
        if ((bus_o.rd_n & bus_o.wr_n) === 1'b0 && prev_strb === 1'b1 && notes.size() != 0) begin
            if (notes[0].wr) chk(bus_o.ad, notes[0].data, "write data");
            else chk({31'h0, bus_o.diag}, {31'h0, notes[0].instr}, "fetch kind");
            void'(notes.pop_front());
        end
        prev_ale  <= bus_o.ale;
        prev_strb <= bus_o.rd_n & bus_o.wr_n;
    end

    task automatic do_reset(input logic trace_n);
        dtr_mode_t m;
        logic      b0;
        int        n;
        m = 5'($random(seed));
        m.addr_trace_mode_n = trace_n;
        @(posedge clk_i);
        reset_n_i   <= 1'b0;
        mode_pins_i <= m;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) b0 = bclk;
        @(negedge clk_i) chk({31'h0, bclk}, {31'h0, ~b0}, "bus clock in reset");
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        mode_pins_i <= ~m;
        n = 0;
        while (core_run !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        chk({31'h0, n >= 2 && n <= 5}, 1, "reset release delay");
        chk({31'h0, bclk}, 1, "bus clock phase at release");
        chk({27'h0, mode_o}, {27'h0, m}, "latched modes");
    endtask

    task automatic acc(input logic hit, cach, instr, dblk4, wr, ext);
        dtr_access_t a;
        dtr_note_t   nt;
        int          n;
        a = '0;
        a.valid = 1'b1;
        a.hit = hit;
        a.cacheable = cach;
        a.instr = instr;
        a.dblk4 = dblk4;
        a.write = wr;
        a.addr = $random(seed);
        a.data = $random(seed);
        if (ext) begin
            nt = '{wr, a.addr, a.data, cach, instr, cach & ~wr & (instr | dblk4)};
            notes.push_back(nt);
        end
        @(posedge clk_i);
        acc_i       <= a;
        wait_cycles <= 2'($random(seed));
        tc_i        <= 1'($random(seed));
        grant_i     <= 1'($random(seed));
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (acc_taken !== 1'b1 && n < 20);
        @(posedge clk_i);
        acc_i.valid <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, n < 20}, 1, "access taken");
        chk({31'h0, ext_req}, {31'h0, ext}, "external cycle");
        n = 0;
        while (ext_req !== 1'b0 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk({31'h0, n < 40}, 1, "cycle end");
        chk({30'h0, tc_o, gnt_o}, {30'h0, tc_i, grant_i}, "pin copies");
    endtask

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    initial begin
        do_reset(1'b1);
        acc(1, 1, 1, 0, 0, 0);
        chk({31'h0, bus_o.ad_oe}, 0, "idle bus released");
        acc(1, 0, 0, 0, 0, 1);
        acc(0, 1, 1, 0, 0, 1);
        do_reset(1'b0);
        @(posedge clk_i);
        tag_i   <= 23'($random(seed));
        index_i <= 9'($random(seed));
        repeat (10) @(negedge clk_i);
        chk(trc_word, {tag_i, index_i.mid, index_i.hi, TRACE_RSVD}, "trace word");
        chk({30'h0, bus_o.addr_lo}, {30'h0, index_i.lo}, "trace low index");
        chk({29'h0, trc_ok, bus_o.ale, bus_o.addr_lo_oe}, 3'h5, "trace no strobe");
        acc(1, 1, 1, 0, 0, 1);
        acc(1, 1, 0, 1, 0, 1);
        acc(1, 1, 0, 0, 0, 1);
        acc(1, 1, 0, 0, 1, 1);
        @(posedge clk_i) float_n <= 1'b0;
        repeat (6) @(negedge clk_i);
        chk({bus_o.ad_oe, bus_o.ctl_oe, bus_o.diag_oe, bus_o.addr_lo_oe, bclk_oe, tc_oe, gnt_oe},
            0, "floated outputs");
        @(posedge clk_i) float_n <= 1'b1;
        repeat (6) @(negedge clk_i);
        chk({bus_o.ctl_oe, bus_o.diag_oe, bclk_oe, tc_oe, gnt_oe}, 0, "float held");
        do_reset(1'b1);
        chk({bus_o.ctl_oe, bus_o.diag_oe, bclk_oe, tc_oe, gnt_oe}, 5'h1f, "float left");
        stop_test();
    end
endmodule // debug_trace_and_reset_modes_tb
`default_nettype wire

//--- dtr_debug_core.sv
`timescale 1ns/1ps
`default_nettype none
module dtr_debug_core (
    input  wire logic                         clk_i,                 // 25 MHz input clock
    input  wire logic                         reset_n_i,             // Async reset pin
    input  wire logic                         ce_i,                  // Clock enable
    input  wire dtr_pkg::dtr_mode_t           mode_pins_i,           // Config pins
    input  wire logic                         float_all_outputs_n_i, // Float pin
    input  wire dtr_pkg::dtr_access_t         acc_i,                 // Core cache access
    input  wire logic                         bus_ack_i,             // Bus cycle done
    input  wire logic [dtr_pkg::TAG_W-1:0]    tag_i,                 // Cache tag response
    input  wire dtr_pkg::dtr_index_t          index_i,               // Cache index
    input  wire logic                         tc_i,                  // Core terminal count
    input  wire logic                         grant_i,               // Core bus grant
    output var  dtr_pkg::dtr_mode_t           mode_o,                // Latched modes
    output logic                              core_run_o,            // Core out of reset
    output logic                              acc_taken_o,           // Access accepted
    output logic                              ext_req_o,             // External cycle busy
    output logic                              burst_o,               // Burst refill
    output logic                              bus_clock_out_o,       // Bus clock pin
    output logic                              bus_clock_out_oe_o,    // Bus clock enable
    output var  dtr_pkg::dtr_bus_t            bus_o,                 // Bus pins and enables
    output logic                              terminal_count_out_o,  // Terminal count pin
    output logic                              terminal_count_out_oe_o, // Its enable
    output logic                              bus_grant_out_o,       // Bus grant pin
    output logic                              bus_grant_out_oe_o     // Its enable
);
    import dtr_pkg::*;

    typedef struct packed {
        logic            bclk;
        logic            run;
        logic            f1;
        logic            f2;
        logic            f3;
        logic            flt;
        dtr_bus_state_t  st;
        dtr_access_t     cur;
        dtr_index_t      idx_cap;
        dtr_trace_word_t trace;
        logic [IDX_LO_W-1:0] trace_lo;
        dtr_bus_t        bus;
        logic            ext;
        logic            burst;
        logic            tc;
        logic            grant;
    } dtr_core_st_t;

    dtr_core_st_t s_ff;
    dtr_core_st_t nxt_s;
    logic         rst_n;
    logic         tick;
    logic         half;
    logic         force_miss;
    logic         trace_on;
    logic         miss;
    logic         burst_kind;
    logic         float_req;
    dtr_trace_word_t trace_view;

    dtr_reset_sync u_sync (
        .clk_i     (clk_i),
        .ce_i      (ce_i),
        .reset_n_i (reset_n_i),
        .rst_n_o   (rst_n)
    );

    dtr_mode_latch u_mode (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .mode_pins_i (mode_pins_i),
        .mode_o      (mode_o)
    );

    // Bus outputs move when the bus clock falls, so rising-edge samplers see settled data
    assign tick       = rst_n & s_ff.run & s_ff.bclk;
    assign half       = rst_n & s_ff.run & ~s_ff.bclk;
    assign trace_on   = ~mode_o.addr_trace_mode_n;
    assign force_miss = ~mode_o.addr_trace_mode_n;
    assign miss       = ~acc_i.hit | ~acc_i.cacheable | force_miss;
    assign burst_kind = acc_i.cacheable & ~acc_i.write & (acc_i.instr | acc_i.dblk4);
    assign float_req  = ~s_ff.f2 & ~s_ff.f3;

    always_comb begin
        nxt_s = s_ff;
        if (ce_i) begin
            nxt_s.f1    = float_all_outputs_n_i;
            nxt_s.f2    = s_ff.f1;
            nxt_s.f3    = s_ff.f2;
            nxt_s.tc    = tc_i;
            nxt_s.grant = grant_i;
            nxt_s.run   = rst_n;
            // Float is sticky; only reset with the pin released clears it
            if (float_req) begin
                nxt_s.flt = 1'h1;
            end else if (!rst_n) begin
                nxt_s.flt = 1'h0;
            end
            // Written as if/else so an unknown start still settles
            if (s_ff.bclk) begin
                nxt_s.bclk = 1'h0;
            end else begin
                nxt_s.bclk = 1'h1;
            end
            if (rst_n && !s_ff.run) begin
                nxt_s.bclk = 1'h1;
            end
            if (!rst_n) begin
                nxt_s.st      = DTR_IDLE;
                nxt_s.cur     = '0;
                nxt_s.idx_cap = '0;
                nxt_s.trace   = '0;
                nxt_s.trace_lo = '0;
                nxt_s.bus     = BUS_RESET;
                nxt_s.ext     = 1'h0;
                nxt_s.burst   = 1'h0;
            end else begin
                if (half) begin
                    nxt_s.idx_cap = index_i;
                end
                if (tick) begin
                    // Tag arrives half a clock after the index; may be stale around refills
                    nxt_s.trace = '{tag: tag_i, idx_mid: s_ff.idx_cap.mid,
                                    idx_hi: s_ff.idx_cap.hi, rsvd: TRACE_RSVD};
                    // Low pins must come from the same capture as the word
                    nxt_s.trace_lo = s_ff.idx_cap.lo;
                    case (s_ff.st)
                        DTR_IDLE: begin
                            nxt_s.bus.ale        = 1'h0;
                            nxt_s.bus.rd_n       = 1'h1;
                            nxt_s.bus.wr_n       = 1'h1;
                            nxt_s.bus.ad         = s_ff.trace;
                            nxt_s.bus.ad_oe      = trace_on;
                            nxt_s.bus.addr_lo    = s_ff.trace_lo;
                            nxt_s.bus.addr_lo_oe = trace_on;
                            nxt_s.ext            = 1'h0;
                            nxt_s.burst          = 1'h0;
                            if (acc_i.valid && miss) begin
                                nxt_s.st             = DTR_ADDR;
                                nxt_s.cur            = acc_i;
                                nxt_s.ext            = 1'h1;
                                nxt_s.burst          = burst_kind;
                                nxt_s.bus.ale        = 1'h1;
                                nxt_s.bus.ad         = acc_i.addr;
                                nxt_s.bus.ad_oe      = 1'h1;
                                nxt_s.bus.addr_lo    = acc_i.addr[ADDR_LO_LSB +: IDX_LO_W];
                                nxt_s.bus.addr_lo_oe = 1'h1;
                                nxt_s.bus.diag       = acc_i.cacheable;
                            end
                        end
                        DTR_ADDR: begin
                            nxt_s.st        = DTR_DATA;
                            nxt_s.bus.ale   = 1'h0;
                            nxt_s.bus.rd_n  = s_ff.cur.write;
                            nxt_s.bus.wr_n  = ~s_ff.cur.write;
                            nxt_s.bus.ad    = s_ff.cur.data;
                            nxt_s.bus.ad_oe = s_ff.cur.write;
                            nxt_s.bus.diag  = s_ff.cur.instr;
                        end
                        DTR_DATA: begin
                            if (bus_ack_i) begin
                                nxt_s.st             = DTR_IDLE;
                                nxt_s.bus.rd_n       = 1'h1;
                                nxt_s.bus.wr_n       = 1'h1;
                                nxt_s.bus.ad_oe      = 1'h0;
                                nxt_s.bus.addr_lo_oe = 1'h0;
                                nxt_s.ext            = 1'h0;
                                nxt_s.burst          = 1'h0;
                            end
                        end
                        default: begin
                            nxt_s.st = DTR_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // Reset is taken through the synchroniser so the divider keeps toggling
    always_ff @(posedge clk_i) begin
        s_ff <= nxt_s;
    end

    assign core_run_o  = s_ff.run;
    assign acc_taken_o = ce_i & tick & (s_ff.st == DTR_IDLE) & acc_i.valid;
    assign ext_req_o   = s_ff.ext;
    assign burst_o     = s_ff.burst;

    assign bus_clock_out_o         = s_ff.bclk;
    assign bus_clock_out_oe_o      = ~s_ff.flt;
    assign terminal_count_out_o    = s_ff.tc;
    assign terminal_count_out_oe_o = ~s_ff.flt;
    assign bus_grant_out_o         = s_ff.grant;
    assign bus_grant_out_oe_o      = ~s_ff.flt;

    always_comb begin
        bus_o            = s_ff.bus;
        bus_o.ad_oe      = s_ff.bus.ad_oe & ~s_ff.flt;
        bus_o.ctl_oe     = s_ff.bus.ctl_oe & ~s_ff.flt;
        bus_o.diag_oe    = s_ff.bus.diag_oe & ~s_ff.flt;
        bus_o.addr_lo_oe = s_ff.bus.addr_lo_oe & ~s_ff.flt;
    end

    assign trace_view = bus_o.ad;

    sequence s_idle_trace;
        trace_on && tick && (s_ff.st == DTR_IDLE) && !acc_i.valid;
    endsequence

    sequence s_capture;
        half ##1 tick;
    endsequence

    sequence s_miss_start;
        tick && (s_ff.st == DTR_IDLE) && acc_i.valid && force_miss;
    endsequence

    property p_float_off;
        @(posedge clk_i) disable iff (!ce_i)
        float_req |=> !bus_clock_out_oe_o && !bus_o.ad_oe && !bus_o.ctl_oe
                      && !terminal_count_out_oe_o && !bus_grant_out_oe_o;
    endproperty
    a_float_off: assert property (p_float_off) else $error("outputs not floated");

    property p_float_sticky;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        s_ff.flt |=> s_ff.flt && !bus_clock_out_oe_o;
    endproperty
    a_float_sticky: assert property (p_float_sticky) else $error("float left without reset");

    property p_phase;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        (rst_n && !s_ff.run) |=> bus_clock_out_o ##1 !bus_clock_out_o;
    endproperty
    a_phase: assert property (p_phase) else $error("bus clock phase not set");

    property p_clock_runs;
        @(posedge clk_i) disable iff (!ce_i)
        (!rst_n && ce_i) ##1 (!rst_n && ce_i) |=> (bus_clock_out_o != $past(bus_clock_out_o));
    endproperty
    a_clock_runs: assert property (p_clock_runs) else $error("bus clock stopped in reset");

    property p_trace_idle;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        s_idle_trace |=> s_ff.bus.ad_oe && !bus_o.ale && (bus_o.ad == $past(s_ff.trace));
    endproperty
    a_trace_idle: assert property (p_trace_idle) else $error("idle trace not driven");

    property p_trace_fields;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        s_idle_trace |=> (trace_view.idx_hi == $past(s_ff.idx_cap.hi, 3))
                         && (trace_view.idx_mid == $past(s_ff.idx_cap.mid, 3))
                         && (bus_o.addr_lo == $past(s_ff.idx_cap.lo, 3))
                         && (trace_view.rsvd == TRACE_RSVD);
    endproperty
    a_trace_fields: assert property (p_trace_fields) else $error("trace word layout wrong");

    property p_tag_half;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        s_capture |=> (s_ff.trace.tag == $past(tag_i))
                      && (s_ff.trace.idx_mid == $past(index_i.mid, 2));
    endproperty
    a_tag_half: assert property (p_tag_half) else $error("tag and index not paired");

    property p_force_miss;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        s_miss_start |=> (s_ff.st == DTR_ADDR) && ext_req_o && bus_o.ale;
    endproperty
    a_force_miss: assert property (p_force_miss) else $error("forced miss stayed internal");

    property p_burst;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        s_miss_start ##0 (acc_i.cacheable && !acc_i.write && acc_i.instr) |=> burst_o;
    endproperty
    a_burst: assert property (p_burst) else $error("refill lost burst");

    property p_diag;
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        (tick && (s_ff.st == DTR_ADDR) && !s_ff.cur.write)
            |-> bus_o.diag == s_ff.cur.cacheable ##1 (bus_o.diag == $past(s_ff.cur.instr)) && !bus_o.rd_n;
    endproperty
    a_diag: assert property (p_diag) else $error("fetch kind pin wrong");

endmodule // dtr_debug_core
`default_nettype wire

//--- dtr_mode_latch.sv
`timescale 1ns/1ps
`default_nettype none
module dtr_mode_latch (
    input  wire logic              clk_i,       // Clock, observation only
    input  wire logic              reset_n_i,   // Reset pin, latch gate
    input  wire dtr_pkg::dtr_mode_t mode_pins_i, // Configuration pins
    output var  dtr_pkg::dtr_mode_t mode_o       // Latched mode vector
);
    import dtr_pkg::*;

    // Transparent during reset, closes on the rising reset edge
    always_latch begin
        if (!reset_n_i) begin
            mode_o <= mode_pins_i;
        end
    end

    property p_mode_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        $past(reset_n_i) |-> $stable(mode_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode vector moved outside reset");

endmodule // dtr_mode_latch
`default_nettype wire

//--- dtr_pkg.sv
`default_nettype none
package dtr_pkg;

    // Multiplexed bus and trace word layout
    localparam int AD_W        = 32;
    localparam int TAG_W       = 23;
    localparam int IDX_MID_W   = 5;
    localparam int IDX_HI_W    = 2;
    localparam int IDX_LO_W    = 2;
    localparam int RSVD_W      = 2;
    localparam int ADDR_LO_LSB = 2;

    localparam logic [RSVD_W-1:0] TRACE_RSVD = 2'h0;

    // Bus bits 31:9 tag, 8:4 index 8:4, 3:2 index 10:9, 1:0 reserved
    typedef struct packed {
        logic [TAG_W-1:0]     tag;
        logic [IDX_MID_W-1:0] idx_mid;
        logic [IDX_HI_W-1:0]  idx_hi;
        logic [RSVD_W-1:0]    rsvd;
    } dtr_trace_word_t;

    // Instruction cache index bits 10:2
    typedef struct packed {
        logic [IDX_HI_W-1:0]  hi;
        logic [IDX_MID_W-1:0] mid;
        logic [IDX_LO_W-1:0]  lo;
    } dtr_index_t;

    // Reset configuration vector; the _n fields are active low
    typedef struct packed {
        logic big_endian;
        logic addr_trace_mode_n;
        logic ext_hold_n;
        logic boot8_n;
        logic boot16_n;
    } dtr_mode_t;

    // Cache access offered by the execution core
    typedef struct packed {
        logic            valid;
        logic            hit;
        logic            cacheable;
        logic            instr;
        logic            dblk4;
        logic            write;
        logic [AD_W-1:0] addr;
        logic [AD_W-1:0] data;
    } dtr_access_t;

    // Bus pins with their output enables
    typedef struct packed {
        logic [AD_W-1:0]     ad;
        logic                ad_oe;
        logic                ale;
        logic                rd_n;
        logic                wr_n;
        logic                ctl_oe;
        logic                diag;
        logic                diag_oe;
        logic [IDX_LO_W-1:0] addr_lo;
        logic                addr_lo_oe;
    } dtr_bus_t;

    localparam dtr_bus_t BUS_RESET = '{
        ad:         '0,
        ad_oe:      1'h0,
        ale:        1'h0,
        rd_n:       1'h1,
        wr_n:       1'h1,
        ctl_oe:     1'h1,
        diag:       1'h0,
        diag_oe:    1'h1,
        addr_lo:    '0,
        addr_lo_oe: 1'h0
    };

    typedef enum logic [1:0] {
        DTR_IDLE,
        DTR_ADDR,
        DTR_DATA
    } dtr_bus_state_t;

endpackage
`default_nettype wire

//--- dtr_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dtr_reset_sync (
    input  wire logic clk_i,       // Input clock
    input  wire logic ce_i,        // Clock enable
    input  wire logic reset_n_i,   // Asynchronous reset pin
    output logic      rst_n_o      // Synchronised reset, low active
);
    import dtr_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } dtr_sync_st_t;

    dtr_sync_st_t s_ff;
    dtr_sync_st_t nxt_s;

    // Late release simply lands one edge later
    always_comb begin
        nxt_s = s_ff;
        if (ce_i) begin
            nxt_s.s1 = 1'h1;
            nxt_s.s2 = s_ff.s1;
            nxt_s.s3 = s_ff.s2;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Release counts once second and third stage are both set
    assign rst_n_o = s_ff.s2 & s_ff.s3;

    property p_release;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && reset_n_i) [*3] |=> rst_n_o;
    endproperty
    a_release: assert property (p_release) else $error("reset release not seen in time");

endmodule // dtr_reset_sync
`default_nettype wire

//--- dtr_tracer.sv
`timescale 1ns/1ps
`default_nettype none
module dtr_tracer (
    input  wire logic             clk_i,       // Input clock
    input  wire logic             reset_n_i,   // Reset pin
    input  wire logic             bus_clock_i, // Bus clock from the device
    input  wire dtr_pkg::dtr_bus_t bus_i,      // Bus pins of the device
    input  wire logic [1:0]       wait_i,      // Wait cycles before ack
    output logic                  bus_ack_o,   // Ends the data phase
    output logic [31:0]           trace_o,     // Last captured bus word
    output logic                  trace_ok_o   // Captured word is usable
);
    import dtr_pkg::*;

    logic [1:0] cnt_ff;
    logic       strb_seen_ff;

    // Ack held until the strobe is seen released, like slow memory
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_ack_o <= 1'h0;
            cnt_ff    <= 2'h0;
        end else if (!bus_i.rd_n || !bus_i.wr_n) begin
            if (cnt_ff >= wait_i) begin
                bus_ack_o <= 1'h1;
            end else begin
                cnt_ff <= cnt_ff + 2'h1;
            end
        end else begin
            bus_ack_o <= 1'h0;
            cnt_ff    <= 2'h0;
        end
    end

    // Strobe ignored; bus word taken on the bus clock rise
    always_ff @(posedge bus_clock_i) begin
        trace_o      <= bus_i.ad;
        strb_seen_ff <= ~(bus_i.rd_n & bus_i.wr_n);
    end

    // Words next to a read or write are not trusted
    assign trace_ok_o = bus_i.rd_n & bus_i.wr_n & bus_i.ad_oe & ~bus_i.ale
                        & ~strb_seen_ff;
endmodule // dtr_tracer
`default_nettype wire
